// >>> iodr_pkg.sv
// Purpose: Constants and types for the I/O diagnostic record builder
// Assumes: AHB-Lite single word transfers, 32-bit data
// Notes:   Each record is 16 bytes, read as four words
package iodr_pkg;

  // Unit class codes and record constants
  localparam logic [3:0] CLASS_DIGITAL   = 4'hf;
  localparam logic [3:0] CLASS_FUNCTION  = 4'h8;
  localparam logic [6:0] CHTYPE_ALARM    = 7'h70;
  localparam logic [6:0] CHTYPE_COUNTER  = 7'h76;
  localparam logic [7:0] DIAG_BITS_PER   = 8'h08;
  localparam logic [7:0] CHAN_CNT_ALARM  = 8'h08;
  localparam logic [7:0] CHAN_CNT_COUNT  = 8'h04;

  // Register byte addresses
  localparam logic [7:0] ADDR_ALM_W0     = 8'h00;
  localparam logic [7:0] ADDR_ALM_W1     = 8'h04;
  localparam logic [7:0] ADDR_ALM_W2     = 8'h08;
  localparam logic [7:0] ADDR_ALM_W3     = 8'h0c;
  localparam logic [7:0] ADDR_CNT_W0     = 8'h10;
  localparam logic [7:0] ADDR_CNT_W1     = 8'h14;
  localparam logic [7:0] ADDR_CNT_W2     = 8'h18;
  localparam logic [7:0] ADDR_CNT_W3     = 8'h1c;
  localparam logic [7:0] ADDR_CTRL       = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h24;
  localparam logic [7:0] ADDR_IRQ_CLR    = 8'h28;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h2c;

  // Control bit positions
  localparam int CTRL_ALM_MORE  = 0;
  localparam int CTRL_CNT_MORE  = 1;
  localparam int IRQ_ALM_SNAP   = 0;
  localparam int IRQ_CNT_SNAP   = 1;

  localparam logic [1:0]  CTRL_RESET = 2'h0;
  localparam logic [1:0]  IRQ_RESET  = 2'h0;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  // Diagnostic sources of one unit, one capture snapshot
  typedef struct packed {
    logic [4:0] basic0;     // Byte 0 bits 4..0
    logic       chan_info;  // Byte 1 bit 4
    logic       int_pwr;    // Byte 2 bit 4
    logic       pi_lost;    // Byte 3 bit 6
    logic [3:0] grp_err;    // Byte 7 bits 3..0
    logic [7:0] lost_a;     // Alarm input lost flags
    logic [3:0] lost_ovf;   // Counter over/underflow/end
    logic [3:0] lost_cmp;   // Counter compare match
    logic [2:0] lost_gl;    // Counter 3 gate open, closed, latch
  } iodr_src_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ADDR  = 3'b010,
    ST_DATA  = 3'b100
  } iodr_bus_e;

  typedef struct packed {
    iodr_src_s   alm;
    iodr_src_s   cnt;
    logic [1:0]  ctrl;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_en;
    iodr_bus_e   bus;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] hrdata;
    logic        rdy;
    logic        irq;
  } iodr_state_s;

endpackage : iodr_pkg

// >>> iodr_record.sv
// Purpose: Builds extended 16-byte diagnostic records for the alarm
//          inputs and the counters, readable over AHB-Lite
// Assumes: Event strobes and source flags synchronous to clock
// Notes:   One wait state on every access; response always OKAY
`timescale 1ns/10ps

// Contract
// - Record is 16 bytes: basic 4, unit specific 8, reserved 4
// - Alarm unit byte 4: type 70h low seven bits, bit 7 more types
// - Counter unit byte 4: type 76h low seven bits, bit 7 more types
// - Byte 5 reports eight diagnostic bits per channel in both records
// - Byte 6 channel count: 08h alarm inputs, 04h counters
// - Alarm byte 7 bits 3..0 flag errors per group of two inputs
// - Alarm bytes 8..11 put lost flags on even bits, odd bits zero
// - Counters 0..2 bytes 8..10: bit 2 overflow lost, bit 3 compare lost
// - Counter 3 byte 11: gate open, closed, overflow, compare, latch lost
// - Counter byte 7 bit n flags an error of counter n
// - Byte 1 holds class code 1111b or 1000b, bit 4 channel info
// - Byte 3 bit 6 set while process interrupt lost is reported
module iodr_record
  import iodr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        alm_event,
  input  wire iodr_src_s   alm_src,
  input  wire logic        cnt_event,
  input  wire iodr_src_s   cnt_src,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq
);

  iodr_state_s r;
  iodr_state_s next_r;

  // First word, bytes 0..3, common to both units
  function automatic logic [31:0] basic_word(iodr_src_s s,
                                             logic [3:0] cls);
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    b0 = {3'h0, s.basic0};
    b1 = {3'h0, s.chan_info, cls};
    b2 = {3'h0, s.int_pwr, 4'h0};
    b3 = {1'h0, s.pi_lost, 6'h00};
    return {b3, b2, b1, b0};
  endfunction : basic_word

  // Alarm lost flag i on bit 2*(i mod 4) of its byte, odd bits zero
  function automatic logic [7:0] alm_lost_byte(logic [3:0] f);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 4; i++) begin
      b[2*i] = f[i];
    end
    return b;
  endfunction : alm_lost_byte

  // Bytes 4..7: type code and more flag, bits per channel, count, errors
  function automatic logic [31:0] type_word(iodr_src_s s, logic more,
                                            logic [6:0] ty,
                                            logic [7:0] cnt);
    logic [7:0] b4;
    logic [7:0] b5;
    logic [7:0] b6;
    logic [7:0] b7;
    b4 = {more, ty};
    b5 = DIAG_BITS_PER;
    b6 = cnt;
    b7 = {4'h0, s.grp_err};
    return {b7, b6, b5, b4};
  endfunction : type_word

  // Record word select; words beyond 3 are not decoded here
  function automatic logic [31:0] alm_word(iodr_src_s s, logic more,
                                           logic [1:0] w);
    logic [31:0] v;
    v = WORD_ZERO;
    case (w)
      2'd0: v = basic_word(s, CLASS_DIGITAL);
      2'd1: v = type_word(s, more, CHTYPE_ALARM, CHAN_CNT_ALARM);
      2'd2: v = alm_lost_word(s);
      2'd3: v = WORD_ZERO;
      default: v = WORD_ZERO;
    endcase
    return v;
  endfunction : alm_word

  function automatic logic [31:0] cnt_word(iodr_src_s s, logic more,
                                           logic [1:0] w);
    logic [31:0] v;
    v = WORD_ZERO;
    case (w)
      2'd0: v = basic_word(s, CLASS_FUNCTION);
      2'd1: v = type_word(s, more, CHTYPE_COUNTER, CHAN_CNT_COUNT);
      2'd2: v = cnt_lost_word(s);
      2'd3: v = WORD_ZERO;
      default: v = WORD_ZERO;
    endcase
    return v;
  endfunction : cnt_word

  // Counter bytes 8..11 form word 2 of the counter record
  function automatic logic [31:0] cnt_lost_word(iodr_src_s s);
    logic [7:0] b8;
    logic [7:0] b9;
    logic [7:0] b10;
    logic [7:0] b11;
    b8  = {4'h0, s.lost_cmp[0], s.lost_ovf[0], 2'h0};
    b9  = {4'h0, s.lost_cmp[1], s.lost_ovf[1], 2'h0};
    b10 = {4'h0, s.lost_cmp[2], s.lost_ovf[2], 2'h0};
    b11 = {3'h0, s.lost_gl[2], s.lost_cmp[3],
           s.lost_ovf[3], s.lost_gl[1], s.lost_gl[0]};
    return {b11, b10, b9, b8};
  endfunction : cnt_lost_word

  // Alarm bytes 8..11; only inputs 0..7 exist, bytes 10 and 11 stay zero
  function automatic logic [31:0] alm_lost_word(iodr_src_s s);
    logic [7:0] b8;
    logic [7:0] b9;
    logic [7:0] b10;
    logic [7:0] b11;
    b8  = alm_lost_byte(s.lost_a[3:0]);
    b9  = alm_lost_byte(s.lost_a[7:4]);
    b10 = 8'h00;
    b11 = 8'h00;
    return {b11, b10, b9, b8};
  endfunction : alm_lost_word

  function automatic logic [31:0] read_mux(iodr_state_s q,
                                           logic [7:0] a);
    logic [31:0] v;
    v = WORD_ZERO;
    case (a)
      ADDR_ALM_W0: v = alm_word(q.alm, q.ctrl[CTRL_ALM_MORE], 2'd0);
      ADDR_ALM_W1: v = alm_word(q.alm, q.ctrl[CTRL_ALM_MORE], 2'd1);
      ADDR_ALM_W2: v = alm_lost_word(q.alm);
      ADDR_ALM_W3: v = alm_word(q.alm, q.ctrl[CTRL_ALM_MORE], 2'd3);
      ADDR_CNT_W0: v = cnt_word(q.cnt, q.ctrl[CTRL_CNT_MORE], 2'd0);
      ADDR_CNT_W1: v = cnt_word(q.cnt, q.ctrl[CTRL_CNT_MORE], 2'd1);
      ADDR_CNT_W2: v = cnt_lost_word(q.cnt);
      ADDR_CNT_W3: v = cnt_word(q.cnt, q.ctrl[CTRL_CNT_MORE], 2'd3);
      ADDR_CTRL:     v = {30'h0, q.ctrl};
      ADDR_IRQ_STAT: v = {30'h0, q.irq_stat};
      ADDR_IRQ_EN:   v = {30'h0, q.irq_en};
      default:       v = WORD_ZERO;
    endcase
    return v;
  endfunction : read_mux

  // Address phase taken: keep direction and offset for the data phase
  function automatic iodr_state_s open_xfer(iodr_state_s q, logic w,
                                            logic [31:0] a);
    iodr_state_s v;
    v = q;
    v.bus  = ST_ADDR;
    v.wr   = w;
    v.addr = a[7:0];
    return v;
  endfunction : open_xfer

  // Register write; record words and unmapped offsets ignore the data
  function automatic iodr_state_s reg_write(iodr_state_s q,
                                            logic [7:0] a,
                                            logic [31:0] d);
    iodr_state_s v;
    v = q;
    case (a)
      ADDR_CTRL:   v.ctrl   = d[1:0];
      ADDR_IRQ_EN: v.irq_en = d[1:0];
      default:     v = q;
    endcase
    return v;
  endfunction : reg_write

  // Sticky status: an event sets its bit, a written one clears it;
  // the set wins when both fall in one cycle
  function automatic logic [1:0] irq_update(logic [1:0] stat,
                                            logic [1:0] set,
                                            logic [1:0] clr);
    logic [1:0] v;
    v = stat;
    for (int n = 0; n < 2; n++) begin
      if (set[n]) begin
        v[n] = 1'b1;
      end else if (clr[n]) begin
        v[n] = 1'b0;
      end
    end
    return v;
  endfunction : irq_update

  always_comb begin
    logic       take;
    logic [1:0] clr;
    logic [1:0] set;
    next_r = r;
    take = hsel && hready && htrans[1];
    clr = 2'h0;
    set = {cnt_event, alm_event};
    // Whole unit snapshot replaced at once, never bit by bit
    if (alm_event) begin
      next_r.alm = alm_src;
    end
    if (cnt_event) begin
      next_r.cnt = cnt_src;
    end
    case (r.bus)
      ST_IDLE: begin
        if (take) begin
          next_r = open_xfer(next_r, hwrite, haddr);
        end
      end
      ST_ADDR: begin
        next_r.bus = ST_DATA;
        if (r.wr) begin
          next_r = reg_write(next_r, r.addr, hwdata);
          if (r.addr == ADDR_IRQ_CLR) begin
            clr = hwdata[1:0];
          end
        end else begin
          next_r.hrdata = read_mux(r, r.addr);
        end
      end
      ST_DATA: begin
        next_r.bus = ST_IDLE;
        if (take) begin
          next_r = open_xfer(next_r, hwrite, haddr);
        end
      end
      default: next_r.bus = ST_IDLE;
    endcase
    next_r.irq_stat = irq_update(r.irq_stat, set, clr);
    next_r.irq = |(next_r.irq_stat & next_r.irq_en);
    // Ready low only in the wait cycle of a data phase
    next_r.rdy = (next_r.bus != ST_ADDR);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r          <= '0;
      r.bus      <= ST_IDLE;
      r.rdy      <= 1'b1;
      r.ctrl     <= CTRL_RESET;
      r.irq_stat <= IRQ_RESET;
      r.irq_en   <= IRQ_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign hrdata    = r.hrdata;
  assign hreadyout = r.rdy;
  assign hresp     = 1'b0;
  assign irq       = r.irq;

endmodule : iodr_record

// >>> iodr_record_bench.sv
// Purpose: Self-checking bench for the diagnostic record builder
// Assumes: Bench is the only AHB-Lite master
// Notes:   Sources change after each event raised by fire to prove the snapshot
`timescale 1ns/10ps
module iodr_record_bench
  import iodr_pkg::*;
;
  logic        clock;
  logic        sys_rst;
  logic        alm_event;
  logic        cnt_event;
  iodr_src_s   alm_src;
  iodr_src_s   cnt_src;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        irq;
  logic [31:0] q;
  iodr_src_s   pats [3];
  int          n_fail;
  int          cmp_count;

  iodr_record dut (.clock(clock), .sys_rst(sys_rst), .alm_event(alm_event),
    .alm_src(alm_src), .cnt_event(cnt_event), .cnt_src(cnt_src),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Wait for hready high at a rising edge, keeping read data from it
  task automatic wait_rdy;
    logic rdy;
    do begin
      @(negedge clock);
      rdy = hreadyout;
      q = hrdata;
      @(posedge clock);
    end while (rdy !== 1'b1);
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask : xfer

  task automatic fire(input bit c, input iodr_src_s s);
    if (c) cnt_src <= s;
    else alm_src <= s;
    cnt_event <= c;
    alm_event <= !c;
    @(posedge clock);
    alm_event <= 1'b0;
    cnt_event <= 1'b0;
    if (c) cnt_src <= iodr_src_s'(~s);
    else alm_src <= iodr_src_s'(~s);
    @(posedge clock);
  endtask : fire

  task automatic cirq(input logic e);
    repeat (3) @(negedge clock);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clock);
  endtask : cirq

  function automatic logic [7:0] spr(input logic [3:0] v);
    return {1'b0, v[3], 1'b0, v[2], 1'b0, v[1], 1'b0, v[0]};
  endfunction : spr

  function automatic logic [31:0] ew(input bit c, input bit m,
                                     input iodr_src_s s, input int k);
    case (k)
      0: return {1'b0, s.pi_lost, 9'h0, s.int_pwr, 7'h0, s.chan_info,
                 c ? 4'h8 : 4'hf, 3'h0, s.basic0};
      1: return {4'h0, s.grp_err, c ? 8'h04 : 8'h08, 8'h08, m,
                 c ? 7'h76 : 7'h70};
      2: if (c) return {3'h0, s.lost_gl[2], s.lost_cmp[3], s.lost_ovf[3],
          s.lost_gl[1:0], 4'h0, s.lost_cmp[2], s.lost_ovf[2], 6'h0,
          s.lost_cmp[1], s.lost_ovf[1], 6'h0, s.lost_cmp[0], s.lost_ovf[0],
          2'h0};
        else return {16'h0, spr(s.lost_a[7:4]), spr(s.lost_a[3:0])};
      default: return 32'h0;
    endcase
  endfunction : ew

  task automatic rec(input bit c, input bit m, input iodr_src_s s);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, {3'h0, c, k[1:0], 2'h0}, 32'h0);
      chk(q, ew(c, m, s, k));
    end
  endtask : rec

  initial begin
    #40000;
    n_fail++;
    print_verdict();
  end

  initial begin
    {sys_rst, alm_event, cnt_event, hsel, hwrite} = 5'h10;
    {alm_src, cnt_src, htrans, haddr, hwdata} = '0;
    {n_fail, cmp_count} = '0;
    pats = '{31'h7fffffff, 31'h2aaaaaaa, 31'h55555555};
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rec(1'b0, 1'b0, '0);
    rec(1'b1, 1'b0, '0);
    xfer(1'b1, ADDR_IRQ_EN, 32'h3);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, ADDR_CTRL, 32'(i + 1));
      fire(1'b0, pats[i]);
      fire(1'b1, iodr_src_s'(~pats[i]));
      rec(1'b0, i[0] == 1'b0, pats[i]);
      rec(1'b1, i >= 1, iodr_src_s'(~pats[i]));
    end
    cirq(1'b1);
    xfer(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h3);
    xfer(1'b1, ADDR_IRQ_CLR, 32'h1);
    xfer(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h2);
    xfer(1'b1, ADDR_IRQ_EN, 32'h1);
    cirq(1'b0);
    xfer(1'b1, ADDR_IRQ_CLR, 32'h3);
    fire(1'b0, pats[1]);
    cirq(1'b1);
    xfer(1'b1, ADDR_IRQ_CLR, 32'h1);
    cirq(1'b0);
    xfer(1'b1, 8'h30, 32'hffffffff);
    xfer(1'b0, 8'h30, 32'h0);
    chk(q, 32'h0);
    xfer(1'b1, ADDR_ALM_W1, 32'hffffffff);
    rec(1'b0, 1'b1, pats[1]);
    fork
      xfer(1'b1, ADDR_IRQ_CLR, 32'h1);
      begin
        @(posedge clock);
        alm_event <= 1'b1;
        @(posedge clock);
        alm_event <= 1'b0;
      end
    join
    xfer(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h1);
    print_verdict();
  end
endmodule : iodr_record_bench

// >>> iodr_record_checker.sv
// Purpose: Bus and record content checks for iodr_record
// Assumes: One slave, hready driven from hreadyout
// Notes:   Content checks fire in the cycle a read completes
`timescale 1ns/10ps
module iodr_record_checker
  import iodr_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq
);
  logic       rdp;
  logic       pw;
  logic [7:0] adr;
  wire        tk = hsel && hready && htrans[1];
  wire        rv = hreadyout && pw && rdp;
  // Track the open transfer so a completing read can be checked
  always_ff @(posedge clock) begin
    pw <= sys_rst ? 1'b0 : !hreadyout;
    if (sys_rst) rdp <= 1'b0;
    else if (tk) rdp <= !hwrite;
    if (tk) adr <= haddr[7:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_one_wait: assert property (tk |=> !hreadyout ##1 hreadyout)
    else $error("data phase not one wait state");
  chk_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> hrdata == 32'h0 && hreadyout && !irq)
    else $error("outputs not quiet after reset");
  chk_rdata_hold: assert property (
    !(!hreadyout && rdp) |=> $stable(hrdata))
    else $error("read data moved without a read");
  chk_word0_fixed: assert property (rv && adr[7:5] == 3'h0
    && adr[3:2] == 2'h0 |-> (hrdata & 32'hbfefe0e0) == 32'h0
    && hrdata[11:8] == (adr[4] ? CLASS_FUNCTION : CLASS_DIGITAL))
    else $error("basic record word wrong");
  chk_alm_type: assert property (rv && adr == ADDR_ALM_W1
    |-> hrdata[6:0] == CHTYPE_ALARM && hrdata[31:28] == 4'h0
    && hrdata[23:8] == {CHAN_CNT_ALARM, DIAG_BITS_PER})
    else $error("alarm type word wrong");
  chk_cnt_type: assert property (rv && adr == ADDR_CNT_W1
    |-> hrdata[6:0] == CHTYPE_COUNTER && hrdata[31:28] == 4'h0
    && hrdata[23:8] == {CHAN_CNT_COUNT, DIAG_BITS_PER})
    else $error("counter type word wrong");
  chk_alm_odd: assert property (rv && adr == ADDR_ALM_W2
    |-> (hrdata & 32'hffffaaaa) == 32'h0) else $error("alarm odd bits set");
  chk_cnt_fixed: assert property (rv && adr == ADDR_CNT_W2
    |-> (hrdata & 32'he0f3f3f3) == 32'h0) else $error("counter zeros set");
  chk_tail_zero: assert property (rv && (adr == ADDR_ALM_W3
    || adr == ADDR_CNT_W3 || adr == ADDR_IRQ_CLR) |-> hrdata == 32'h0)
    else $error("reserved word not zero");
  cov_cnt_read: cover property (rv && adr == ADDR_CNT_W2);
  cov_irq: cover property (irq);
  cov_write: cover property (tk && hwrite);
endmodule : iodr_record_checker

bind iodr_record iodr_record_checker chk_i (
  .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq)
);
